// ---- aocs_channel_store.sv ----
// analog output channel store with refresh controller
// Summary of operation
// R1: each of the eight channels has its own storage word that the host writes directly.
// R2: stored words are fetched in turn, given to the shared converter, and gated to that channel's hold buffer.
// R3: the failure indicator comes on at reset and stays on until software turns it off.
// R4: control bit 11 written as one turns the indicator off; zero leaves it on.
// R5: control bit 10 selects two's-complement coding when one, straight binary when zero.
// R6: a 16-bit write to a channel word keeps only the low 12 bits.
// R7: the windows are placed by host software at run time and the host reads the base addresses first.
// R8: vendor, device and revision codes are readable so the host can find the board.
// R9: control word at even offsets 0x0-0xE, sixteen words at 0x10-0x2E, 0x30-0x3F reserved.
// R10: output disconnect switches stay open after reset until control bit 9 is set.
// R11: one channel is refreshed every 99.0 us with a 450 ns read at slot start, eight slots per 792 us.
// R12: host and refresh collisions stall the later requester; long host stalls end in a retry.
// R13: readback of a channel word shows zeros in the four upper bits.
`timescale 1ns/1ps
module aocs_channel_store
  import aocs_pkg::*;
#(
  parameter int SLOT = aocs_pkg::SLOT_CYCLES
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  // host access from the bus interface device
  input  wire logic                        host_req,
  input  wire logic                        host_wr,
  input  wire logic [aocs_pkg::ADDR_W-1:0] host_addr,
  input  wire logic [aocs_pkg::DATA_W-1:0] host_wdata,
  output logic                             host_ack,
  output logic [aocs_pkg::DATA_W-1:0]      host_rdata,
  // identification
  output logic [15:0]                      vendor_id,
  output logic [15:0]                      device_id,
  output logic [7:0]                       revision_id,
  // converter and multiplexer
  output logic [aocs_pkg::DAC_W-1:0]       dac_data,
  output logic                             dac_load,
  output logic [aocs_pkg::NUM_CH-1:0]      mux_gate,
  // front panel and outputs
  output logic                             fail_led,
  output logic                             outputs_enabled,
  output logic                             twos_complement
);
  import aocs_pkg::*;
  // settle time follows the slot parameter so a short slot still fits
  localparam int SETTLE = SLOT / 2;

  ////////////////////////////////////////////////////////////////////////////
  // storage and control word
  logic [DAC_W-1:0]  sram [NUM_WORDS];
  logic [DATA_W-1:0] ctrl;
  aocs_state_t       state;
  logic [2:0]        chan;
  logic [31:0]       timer;
  logic              slot_start;

  function automatic logic [4:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = 5'((a - SRAM_LO) >> 1);
  endfunction

  wire hit_ctrl  = host_addr <= CTRL_HI;
  wire hit_sram  = (host_addr >= SRAM_LO) && (host_addr <= SRAM_HI);
  wire refr_busy = (state == AOCS_READ);
  // host waits while refresh holds the memory; refresh starts only when no host channel-word request is waiting
  wire host_go   = host_req && !host_ack && !(refr_busy && hit_sram); // R12
  wire refr_go   = slot_start && !(host_req && hit_sram && !host_ack); // R12
  wire [4:0] hidx = word_index(host_addr);
  wire [DATA_W-1:0] sram_rd = {4'h0, sram[hidx[3:0]]}; // R13
  wire [DATA_W-1:0] next_rdata = hit_ctrl ? ctrl : (hit_sram ? sram_rd : 16'h0000); // R9
  logic pend;

  aocs_slot_timer #(.SLOT(SLOT)) u_timer (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .slot_start (slot_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // host side
  always_ff @(posedge clk_sys) begin
    if (host_go && host_wr && hit_sram) begin
      sram[hidx[3:0]] <= host_wdata[DAC_W-1:0]; // R1 R6
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl       <= CTRL_RESET; // R3 R10
      host_ack   <= 1'b0;
      host_rdata <= 16'h0000;
    end else begin
      host_ack <= host_go;
      if (host_go && host_wr && hit_ctrl) begin
        ctrl <= host_wdata;
      end
      if (host_go && !host_wr) begin
        host_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh controller
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state    <= AOCS_IDLE;
      chan     <= 3'h0;
      timer    <= 32'h0000_0000;
      dac_data <= 12'h000;
      dac_load <= 1'b0;
      mux_gate <= 8'h00;
      pend     <= 1'b0;
    end else begin
      dac_load <= 1'b0;
      pend     <= (pend || slot_start) && !refr_go && state == AOCS_IDLE;
      case (state)
        AOCS_IDLE: begin
          mux_gate <= 8'h00;
          if (refr_go || (pend && !(host_req && hit_sram))) begin
            state <= AOCS_READ;
            timer <= 32'h0000_0000;
          end
        end
        AOCS_READ: begin
          timer <= timer + 32'h0000_0001;
          if (timer == 32'(READ_CYCLES - 1)) begin // R11
            dac_data <= sram[{1'b0, chan}]; // R2
            dac_load <= 1'b1;
            state    <= AOCS_SETTLE;
            timer    <= 32'h0000_0000;
          end
        end
        AOCS_SETTLE: begin
          timer <= timer + 32'h0000_0001;
          if (timer == 32'(SETTLE - 1)) begin
            mux_gate <= 8'(1) << chan; // R2
            state    <= AOCS_GATE;
            timer    <= 32'h0000_0000;
          end
        end
        AOCS_GATE: begin
          timer <= timer + 32'h0000_0001;
          if (timer == 32'(SLOT / 8)) begin
            mux_gate <= 8'h00;
            chan     <= chan + 3'h1; // R11
            state    <= AOCS_IDLE;
          end
        end
        default: state <= AOCS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs and identification
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fail_led        <= 1'b1; // R3
      outputs_enabled <= 1'b0; // R10
      twos_complement <= 1'b0;
      vendor_id       <= 16'h0000;
      device_id       <= 16'h0000;
      revision_id     <= 8'h00;
    end else begin
      fail_led        <= !ctrl[BIT_LED_OFF]; // R4
      outputs_enabled <= ctrl[BIT_OUT_EN]; // R10
      twos_complement <= ctrl[BIT_TWOS]; // R5
      vendor_id       <= VENDOR_CODE; // R8 R7
      device_id       <= DEVICE_CODE; // R8
      revision_id     <= REVISION_CODE; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read length counter for the checks
  logic [7:0] read_len;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      read_len <= 8'h00;
    end else if (refr_busy) begin
      read_len <= read_len + 8'h01;
    end else begin
      read_len <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_led_follows_bit: assert property (@(posedge clk_sys) disable iff (!reset_n) // R4
    host_go && host_wr && hit_ctrl |=> ##1 fail_led == !$past(host_wdata[BIT_LED_OFF], 2))
    else $error("fail led does not follow control bit");
  a_format_bit: assert property (@(posedge clk_sys) disable iff (!reset_n) // R5
    ##1 twos_complement == $past(ctrl[BIT_TWOS]))
    else $error("format select wrong");
  a_switch_enable: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
    ##1 outputs_enabled == $past(ctrl[BIT_OUT_EN]))
    else $error("disconnect switch control wrong");
  a_readback_upper: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
    host_go && !host_wr && hit_sram |=> host_rdata[15:12] == 4'h0)
    else $error("upper readback bits not zero");
  a_no_collision: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
    host_ack |-> !($past(refr_busy) && $past(hit_sram)))
    else $error("host and refresh both on memory");
  a_mux_onehot: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
    $onehot0(mux_gate))
    else $error("more than one channel gated");
  a_gate_after_load: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
    $rose(dac_load) |-> mux_gate == 8'h00)
    else $error("mux closed during converter load");
  a_read_length: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
    $rose(refr_busy) |-> refr_busy [*8])
    else $error("refresh read shorter than expected");
  a_read_count: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
    $fell(refr_busy) && $past(reset_n) |-> read_len == 8'(READ_CYCLES))
    else $error("refresh read length wrong");
  a_reset_state: assert property (@(posedge clk_sys) // R3
    reset_n && !$past(reset_n) |-> fail_led && !outputs_enabled && mux_gate == 8'h00)
    else $error("outputs not in reset state after reset");
  a_ack_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
    host_ack |=> !host_ack)
    else $error("host ack longer than one cycle");
  a_load_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
    dac_load |=> !dac_load)
    else $error("converter load longer than one cycle");
endmodule // aocs_channel_store

// ---- aocs_pkg.sv ----
// constants for the analog output channel store
package aocs_pkg;
  localparam int          DATA_W        = 16;
  localparam int          ADDR_W        = 6;
  localparam int          DAC_W         = 12;
  localparam int          NUM_CH        = 8;
  localparam int          NUM_WORDS     = 16;
  localparam int          CLK_MHZ       = 250;
  localparam logic [5:0]  CTRL_LO       = 6'h00;
  localparam logic [5:0]  CTRL_HI       = 6'h0E;
  localparam logic [5:0]  SRAM_LO       = 6'h10;
  localparam logic [5:0]  SRAM_HI       = 6'h2E;
  localparam int          BIT_OUT_EN    = 9;
  localparam int          BIT_TWOS      = 10;
  localparam int          BIT_LED_OFF   = 11;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam int          SLOT_NS       = 99000;
  localparam int          READ_NS       = 450;
  localparam int          SLOT_CYCLES   = (SLOT_NS * CLK_MHZ) / 1000;
  localparam int          READ_CYCLES   = (READ_NS * CLK_MHZ + 999) / 1000;
  localparam int          SETTLE_CYCLES = SLOT_CYCLES / 2;
  // identification codes are arbitrary neutral values
  localparam logic [15:0] VENDOR_CODE   = 16'h0A5A;
  localparam logic [15:0] DEVICE_CODE   = 16'h0B6B;
  localparam logic [7:0]  REVISION_CODE = 8'h01;
  typedef enum logic [1:0] {
    AOCS_IDLE   = 2'b00,
    AOCS_READ   = 2'b01,
    AOCS_SETTLE = 2'b10,
    AOCS_GATE   = 2'b11
  } aocs_state_t;
endpackage

// ---- aocs_slot_timer.sv ----
// refresh slot timer: one pulse per slot
`timescale 1ns/1ps
module aocs_slot_timer #(
  parameter int SLOT = 24750
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // slot start pulse
  output logic      slot_start
);
  logic [31:0] count;
  wire         at_end = (count == 32'(SLOT - 1));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count      <= 32'h0000_0000;
      slot_start <= 1'b0;
    end else begin
      count      <= at_end ? 32'h0000_0000 : count + 32'h0000_0001;
      slot_start <= at_end;
    end
  end
endmodule // aocs_slot_timer

// ---- aocs_host_model.sv ----
// host bus master model for the channel store
`timescale 1ns/1ps
module aocs_host_model
  import aocs_pkg::*;
(
  // clock and answer
  input  wire logic                   clk_sys,
  input  wire logic                   host_ack,
  // request
  output logic                        host_req,
  output logic                        host_wr,
  output logic [aocs_pkg::ADDR_W-1:0] host_addr,
  output logic [aocs_pkg::DATA_W-1:0] host_wdata
);
  initial begin
    host_req   = 1'b0;
    host_wr    = 1'b0;
    host_addr  = 6'h3F;
    host_wdata = 16'h0000;
  end
  // hold everything until ack is seen or 400 cycles pass, then release with inverted lines
  task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    host_req   = 1'b1;
    host_wr    = wr;
    host_addr  = a;
    host_wdata = d;
    do begin
      @(negedge clk_sys);
      n++;
    end while (host_ack !== 1'b1 && n < 400);
    host_req   = 1'b0;
    host_wr    = ~wr;
    host_addr  = ~a;
    host_wdata = ~d;
  endtask
endmodule // aocs_host_model

// ---- aocs_channel_store_test.sv ----
// self-checking bench for the channel store
`timescale 1ns/1ps
module aocs_channel_store_test;
  import aocs_pkg::*;
  logic        clk_sys = 1'b0, reset_n = 1'b0;
  logic        host_req, host_wr, host_ack, dac_load, fail_led, outputs_enabled, twos_complement;
  logic [5:0]  host_addr;
  logic [15:0] host_wdata, host_rdata, vendor_id, device_id, w[16];
  logic [11:0] dac_data;
  logic [7:0]  revision_id, mux_gate, gated;
  logic [2:0]  cnt, last_ch;
  logic [31:0] seed = 32'h0000_ca65;
  logic [16:0] ack_q[$];
  logic [15:0] dac_q[$];
  int          n_errors = 0, check_count = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  aocs_host_model host (.clk_sys(clk_sys), .host_ack(host_ack), .host_req(host_req), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata));
  aocs_channel_store #(.SLOT(400)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .host_req(host_req),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata), .host_ack(host_ack),
    .host_rdata(host_rdata), .vendor_id(vendor_id), .device_id(device_id), .revision_id(revision_id),
    .dac_data(dac_data), .dac_load(dac_load), .mux_gate(mux_gate), .fail_led(fail_led),
    .outputs_enabled(outputs_enabled), .twos_complement(twos_complement));
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // note the expected answer, then run the access
  task automatic acc(input logic wr, input logic [5:0] a, input logic [15:0] d, input logic [15:0] e);
    ack_q.push_back({~wr, e});
    host.access(wr, a, d);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // monitor: answers, converter loads and hold gates
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
    if (reset_n === 1'b0) begin
      cnt     <= 3'h0;
      last_ch <= 3'h0;
      gated   <= 8'h00;
    end else if (dac_load === 1'b1) begin
      last_ch <= cnt;
      cnt     <= cnt + 3'h1;
      if (dac_q.size() > 0) chk("dac_data", dac_q.pop_front(), {4'h0, dac_data});
    end
    if (mux_gate !== 8'h00) chk("mux_gate", 16'h0001 << last_ch, {8'h00, mux_gate});
    if (reset_n === 1'b1) gated <= gated | mux_gate;
    if (host_ack === 1'b1) begin
      if (ack_q.size() == 0) chk("ack_count", 16'h0000, 16'h0001);
      else begin
        if (ack_q[0][16]) chk("host_rdata", ack_q[0][15:0], host_rdata);
        void'(ack_q.pop_front());
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("vendor_id", VENDOR_CODE, vendor_id);
    chk("device_id", DEVICE_CODE, device_id);
    chk("revision_id", {8'h00, REVISION_CODE}, {8'h00, revision_id});
    chk("fail_led", 16'h0001, {15'h0, fail_led});
    chk("outputs_enabled", 16'h0000, {15'h0, outputs_enabled});
    $display("test reset_state done");
    for (int i = 0; i < 16; i++) begin
      w[i] = rnd();
      acc(1'b1, SRAM_LO + 6'(2 * i), w[i], 16'h0000);
    end
    for (int i = 0; i < 16; i++) acc(1'b0, SRAM_LO + 6'(2 * i), 16'h0000, {4'h0, w[i][11:0]});
    acc(1'b1, 6'h30, rnd(), 16'h0000);
    acc(1'b0, 6'h3E, 16'h0000, 16'h0000);
    $display("test channel_words done");
    acc(1'b1, {2'b00, 4'(rnd() & 16'h000E)}, 16'h0A80, 16'h0000);
    @(negedge clk_sys);
    chk("fail_led", 16'h0000, {15'h0, fail_led});
    chk("outputs_enabled", 16'h0001, {15'h0, outputs_enabled});
    chk("twos_complement", 16'h0000, {15'h0, twos_complement});
    acc(1'b1, 6'h0E, 16'h0400, 16'h0000);
    @(negedge clk_sys);
    chk("twos_complement", 16'h0001, {15'h0, twos_complement});
    chk("outputs_enabled", 16'h0000, {15'h0, outputs_enabled});
    chk("fail_led", 16'h0001, {15'h0, fail_led});
    $display("test control_word done");
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    for (int i = 0; i < 9; i++) dac_q.push_back({4'h0, w[i % 8][11:0]});
    @(negedge clk_sys);
    chk("fail_led", 16'h0001, {15'h0, fail_led});
    chk("twos_complement", 16'h0000, {15'h0, twos_complement});
    for (int n = 0; n < 4000 && dac_q.size() > 0; n++) @(negedge clk_sys);
    chk("dac_pending", 16'h0000, 16'(dac_q.size()));
    chk("gated", 16'h00FF, {8'h00, gated});
    chk("ack_pending", 16'h0000, 16'(ack_q.size()));
    $display("test refresh_cycle done");
    finish_test();
  end
endmodule // aocs_channel_store_test
